//--- rss_defines.svh
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// register byte offsets
`define RSS_ADDR_CFG        12'h000
`define RSS_ADDR_CAUSE      12'h004
`define RSS_ADDR_STAT       12'h008
`define RSS_ADDR_CTRL       12'h00c

// configuration register fields
`define RSS_CFG_OSCM_LSB    0
`define RSS_CFG_FAIL_SAFE_CLOCK_MONITOR        2
`define RSS_CFG_TWOSPD      3
`define RSS_CFG_LOW_POWER_BROWNOUT_DETECTOR       4
`define RSS_CFG_PINEN       5
`define RSS_CFG_LVP         6
`define RSS_CFG_STKRST      7
`define RSS_CFG_PWRTEN      8
`define RSS_CFG_BROWNOUT_ENABLE_FIELD_LSB   9
`define RSS_CFG_RST         32'h0000_0620
`define RSS_CFG_WMASK       32'h0000_07ff

// reset cause register fields
`define RSS_CAUSE_POR_N     0
`define RSS_CAUSE_BOR_N     1
`define RSS_CAUSE_RI_N      2
`define RSS_CAUSE_PIN_N     3
`define RSS_CAUSE_TO_N      4
`define RSS_CAUSE_PD_N      5
`define RSS_CAUSE_UNF       6
`define RSS_CAUSE_OVF       7
`define RSS_CAUSE_RST       8'h3e

// control register fields
`define RSS_CTRL_PULLUP     0
`define RSS_CTRL_SBOREN     1
`define RSS_CTRL_RST        2'h0

// status register fields
`define RSS_STAT_STATE_LSB  0
`define RSS_STAT_CORE_RUN   3
`define RSS_STAT_PC_HOLD    4
`define RSS_STAT_OSC_OK     5
`define RSS_STAT_PIN_EN     6
`define RSS_STAT_PIN_LVL    7
`define RSS_STAT_POWER_UP_DELAY_DONE  8

// timing
`define RSS_CLK_MHZ         40
`define RSS_POWER_UP_DELAY_TIME_US    1000
`define RSS_OST_COUNT       11'h400
`define RSS_PIN_REL_CYC     4'ha
`define RSS_PIN_FILT_CYC    3'h4

`endif

//--- rss_pkg.sv
package rss_pkg;

  typedef enum logic [2:0] {
    RSS_HOLD,
    RSS_PIN_REL,
    RSS_OST,
    RSS_RUN,
    RSS_SLEEP
  } rss_state_e;

  typedef enum logic [1:0] {
    RSS_OSC_INTERNAL,
    RSS_OSC_LOW_FREQ_CRYSTAL,
    RSS_OSC_MEDIUM_CRYSTAL,
    RSS_OSC_HIGH_SPEED_CRYSTAL
  } rss_osc_mode_e;

endpackage

//--- rss_pin_filter.sv
`timescale 1ns/1ps
`include "rss_defines.svh"

// synchronises the external reset pin and passes a level only once it
// has been stable for the filter length, so narrow glitches are dropped
module rss_pin_filter (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin side
  input  wire logic pin_async,
  // filtered level
  output logic      pin_filtered
);

  logic       sync1_ff;
  logic       sync2_ff;
  logic [2:0] stable_cnt_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= pin_async;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_cnt_ff <= 3'h0;
      pin_filtered  <= 1'b1;
    end else if (sync2_ff == pin_filtered) begin
      stable_cnt_ff <= 3'h0;
    end else if (stable_cnt_ff == `RSS_PIN_FILT_CYC - 3'h1) begin
      stable_cnt_ff <= 3'h0;
      pin_filtered  <= sync2_ff;
    end else begin
      stable_cnt_ff <= stable_cnt_ff + 3'h1;
    end
  end

endmodule

//--- rss_reset_sequencer.sv
`timescale 1ns/1ps
`include "rss_defines.svh"

// Functional notes
// - in a crystal mode, count 1024 crystal edges before the clock is stable
// - crystal count starts after power-on once delay ends, and on wake-up
// - core halted during crystal count, unless fail-safe or two-speed enabled
// - low-power brown-out holds reset and clears the shared brown-out flag
// - low-power detector has its own enable bit, disabled after erase
// - pin reset off only when pin-enable and low-voltage bits are both 0
// - enabled pin held low keeps the device in reset; weak pull-up on
// - pin reset path filters out short glitches
// - internal resets never drive the reset pin; it stays input only
// - pin disabled acts as general input with software pull-up
// - watchdog timeout resets and updates expiry and power-down flags
// - reset instruction resets and writes 0 to its cause flag
// - with stack-fault enable set, overflow or underflow resets and flags
// - leaving programming mode behaves like a power-on reset
// - enabled power-up delay runs after power-on or brown-out reset
// - execution starts only after delay done and enabled pin released
// - delay independent of pin; late pin release adds 10 cycles
module rss_reset_sequencer
  import rss_pkg::*;
#(
  parameter int unsigned POWER_UP_DELAY_CYCLES = `RSS_POWER_UP_DELAY_TIME_US * `RSS_CLK_MHZ
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // asynchronous monitors and pins
  input  wire logic        brownout_low,
  input  wire logic        lp_brownout_low,
  input  wire logic        prog_mode,
  input  wire logic        crystal_input_pin,
  input  wire logic        external_reset_pin_in,
  output logic             external_reset_pin_out,
  output logic             external_reset_pin_oe,
  output logic             external_reset_pin_pullup,
  output logic             external_reset_pin_gpio,
  // core events
  input  wire logic        watchdog_timeout,
  input  wire logic        reset_instr,
  input  wire logic        stack_overflow,
  input  wire logic        stack_underflow,
  input  wire logic        sleep_enter,
  input  wire logic        wake_event,
  // core control
  output logic             core_reset_n,
  output logic             pc_hold,
  output logic             clk_sel_internal,
  output logic             osc_stable
);

  localparam int NSYNC = 4;

  rss_state_e  state_ff;
  rss_state_e  nxt_state;
  logic [31:0] cfg_ff;
  logic [7:0]  cause_ff;
  logic [7:0]  nxt_cause;
  logic [1:0]  ctrl_ff;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic        prog_d_ff;
  logic        xtal_d_ff;
  logic        pin_filt;
  logic        need_power_up_delay_ff;
  logic [31:0] power_up_delay_cnt_ff;
  logic        pin_late_ff;
  logic [3:0]  dly_cnt_ff;
  logic [10:0] ost_cnt_ff;
  logic [31:0] rd_mux;
  logic        rd_hit;

  logic        bor_s;
  logic        low_power_brownout_detector_s;
  logic        prog_s;
  logic        xtal_s;
  logic        crystal_mode;
  logic        keep_running;
  logic        pin_enabled;
  logic        pin_hold;
  logic        bor_armed;
  logic        bor_hold;
  logic        low_power_brownout_detector_hold;
  logic        supply_hold;
  logic        prog_exit;
  logic        stk_evt;
  logic        pulse_rst;
  logic        src_hold;
  logic        power_up_delay_expired;
  logic        power_up_delay_done;
  logic        xtal_edge;
  logic        ost_done;
  logic        apb_setup;
  logic        apb_wr;
  logic [1:0]  brownout_enable_field;

  // two-flop synchronisers for the asynchronous levels
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= (gi == 0) ? brownout_low :
                          (gi == 1) ? lp_brownout_low :
                          (gi == 2) ? prog_mode : crystal_input_pin;
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  assign bor_s   = sync2_ff[0];
  assign low_power_brownout_detector_s = sync2_ff[1];
  assign prog_s  = sync2_ff[2];
  assign xtal_s  = sync2_ff[3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_d_ff <= 1'b0;
      xtal_d_ff <= 1'b0;
    end else begin
      prog_d_ff <= prog_s;
      xtal_d_ff <= xtal_s;
    end
  end

  rss_pin_filter u_pin_filter (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_async    (external_reset_pin_in),
    .pin_filtered (pin_filt)
  );

  // source decode
  assign crystal_mode = cfg_ff[`RSS_CFG_OSCM_LSB +: 2] != RSS_OSC_INTERNAL;
  assign keep_running = cfg_ff[`RSS_CFG_FAIL_SAFE_CLOCK_MONITOR] | cfg_ff[`RSS_CFG_TWOSPD];
  assign pin_enabled  = cfg_ff[`RSS_CFG_PINEN] | cfg_ff[`RSS_CFG_LVP];
  assign pin_hold     = pin_enabled & ~pin_filt;
  assign brownout_enable_field        = cfg_ff[`RSS_CFG_BROWNOUT_ENABLE_FIELD_LSB +: 2];
  assign bor_armed    = (brownout_enable_field == 2'h3) |
                        ((brownout_enable_field == 2'h2) & (state_ff != RSS_SLEEP)) |
                        ((brownout_enable_field == 2'h1) & ctrl_ff[`RSS_CTRL_SBOREN]);
  assign bor_hold     = bor_armed & bor_s;
  assign low_power_brownout_detector_hold   = cfg_ff[`RSS_CFG_LOW_POWER_BROWNOUT_DETECTOR] & low_power_brownout_detector_s;
  assign supply_hold  = bor_hold | low_power_brownout_detector_hold | prog_s;
  assign prog_exit    = prog_d_ff & ~prog_s;
  assign stk_evt      = cfg_ff[`RSS_CFG_STKRST] &
                        (stack_overflow | stack_underflow);
  assign pulse_rst    = watchdog_timeout | reset_instr | stk_evt;
  assign src_hold     = supply_hold | pin_hold;

  // power-up delay runs regardless of the pin
  assign power_up_delay_expired = power_up_delay_cnt_ff == POWER_UP_DELAY_CYCLES;
  assign power_up_delay_done    = ~need_power_up_delay_ff | ~cfg_ff[`RSS_CFG_PWRTEN] |
                        power_up_delay_expired;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      need_power_up_delay_ff <= 1'b1;
    end else if (supply_hold || prog_exit) begin
      need_power_up_delay_ff <= 1'b1;
    end else if (nxt_state == RSS_RUN) begin
      need_power_up_delay_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_up_delay_cnt_ff <= 32'h0;
    end else if (supply_hold) begin
      power_up_delay_cnt_ff <= 32'h0;
    end else if (need_power_up_delay_ff && !power_up_delay_expired) begin
      power_up_delay_cnt_ff <= power_up_delay_cnt_ff + 32'h1;
    end
  end

  // pin still low after the delay expired: release adds a fixed delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_late_ff <= 1'b0;
    end else if (state_ff == RSS_RUN) begin
      pin_late_ff <= 1'b0;
    end else if (pin_hold && power_up_delay_done && state_ff == RSS_HOLD) begin
      pin_late_ff <= 1'b1;
    end
  end

  assign xtal_edge = xtal_s & ~xtal_d_ff;
  assign ost_done  = ost_cnt_ff == `RSS_OST_COUNT;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RSS_HOLD: begin
        if (!src_hold && !pulse_rst && power_up_delay_done) begin
          if (pin_late_ff) begin
            nxt_state = RSS_PIN_REL;
          end else begin
            nxt_state = crystal_mode ? RSS_OST : RSS_RUN;
          end
        end
      end
      RSS_PIN_REL: begin
        if (dly_cnt_ff == `RSS_PIN_REL_CYC - 4'h1) begin
          nxt_state = crystal_mode ? RSS_OST : RSS_RUN;
        end
      end
      RSS_OST: begin
        if (ost_done) begin
          nxt_state = RSS_RUN;
        end
      end
      RSS_RUN: begin
        if (sleep_enter) begin
          nxt_state = RSS_SLEEP;
        end
      end
      RSS_SLEEP: begin
        if (wake_event) begin
          nxt_state = crystal_mode ? RSS_OST : RSS_RUN;
        end
      end
      default: begin
        nxt_state = RSS_HOLD;
      end
    endcase
    if (src_hold || pulse_rst) begin
      nxt_state = RSS_HOLD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RSS_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt_ff <= 4'h0;
    end else if (state_ff == RSS_PIN_REL) begin
      dly_cnt_ff <= dly_cnt_ff + 4'h1;
    end else begin
      dly_cnt_ff <= 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_cnt_ff <= 11'h0;
    end else if (state_ff != RSS_OST) begin
      ost_cnt_ff <= 11'h0;
    end else if (xtal_edge && !ost_done) begin
      ost_cnt_ff <= ost_cnt_ff + 11'h1;
    end
  end

  // core control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_n     <= 1'b0;
      pc_hold          <= 1'b1;
      clk_sel_internal <= 1'b1;
      osc_stable       <= 1'b0;
    end else begin
      core_reset_n     <= (nxt_state == RSS_OST) | (nxt_state == RSS_RUN) |
                          (nxt_state == RSS_SLEEP);
      pc_hold          <= (nxt_state != RSS_RUN) &
                          ~((nxt_state == RSS_OST) & keep_running);
      clk_sel_internal <= (nxt_state != RSS_RUN) | ~crystal_mode;
      osc_stable       <= nxt_state == RSS_RUN;
    end
  end

  // reset pin is never driven; pull-up follows pin mode
  assign external_reset_pin_out = 1'b0;
  assign external_reset_pin_oe  = 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_reset_pin_pullup <= 1'b1;
      external_reset_pin_gpio   <= 1'b1;
    end else begin
      external_reset_pin_pullup <= pin_enabled |
                                   ctrl_ff[`RSS_CTRL_PULLUP];
      external_reset_pin_gpio   <= pin_enabled ? 1'b1 : pin_filt;
    end
  end

  // apb slave, zero wait states
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign pready    = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= `RSS_CFG_RST;
    end else if (apb_wr && paddr == `RSS_ADDR_CFG) begin
      cfg_ff <= pwdata & `RSS_CFG_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `RSS_CTRL_RST;
    end else if (apb_wr && paddr == `RSS_ADDR_CTRL) begin
      ctrl_ff <= pwdata[1:0];
    end
  end

  // cause flags live outside the sequenced reset; hardware beats software
  always_comb begin
    nxt_cause = cause_ff;
    if (apb_wr && paddr == `RSS_ADDR_CAUSE) begin
      nxt_cause = pwdata[7:0];
    end
    if (prog_exit) begin
      nxt_cause[`RSS_CAUSE_POR_N] = 1'b0;
    end
    if (bor_hold || low_power_brownout_detector_hold) begin
      nxt_cause[`RSS_CAUSE_BOR_N] = 1'b0;
    end
    if (pin_hold) begin
      nxt_cause[`RSS_CAUSE_PIN_N] = 1'b0;
    end
    if (reset_instr) begin
      nxt_cause[`RSS_CAUSE_RI_N] = 1'b0;
    end
    if (sleep_enter && state_ff == RSS_RUN) begin
      nxt_cause[`RSS_CAUSE_PD_N] = 1'b0;
    end
    if (watchdog_timeout) begin
      nxt_cause[`RSS_CAUSE_TO_N] = 1'b0;
      nxt_cause[`RSS_CAUSE_PD_N] = state_ff != RSS_SLEEP;
    end
    if (cfg_ff[`RSS_CFG_STKRST] && stack_overflow) begin
      nxt_cause[`RSS_CAUSE_OVF] = 1'b1;
    end
    if (cfg_ff[`RSS_CFG_STKRST] && stack_underflow) begin
      nxt_cause[`RSS_CAUSE_UNF] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= `RSS_CAUSE_RST;
    end else begin
      cause_ff <= nxt_cause;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (paddr)
      `RSS_ADDR_CFG:   rd_mux = cfg_ff;
      `RSS_ADDR_CAUSE: rd_mux = {24'h0, cause_ff};
      `RSS_ADDR_CTRL:  rd_mux = {30'h0, ctrl_ff};
      `RSS_ADDR_STAT: begin
        rd_mux[`RSS_STAT_STATE_LSB +: 3] = state_ff;
        rd_mux[`RSS_STAT_CORE_RUN]       = core_reset_n;
        rd_mux[`RSS_STAT_PC_HOLD]        = pc_hold;
        rd_mux[`RSS_STAT_OSC_OK]         = osc_stable;
        rd_mux[`RSS_STAT_PIN_EN]         = pin_enabled;
        rd_mux[`RSS_STAT_PIN_LVL]        = pin_filt;
        rd_mux[`RSS_STAT_POWER_UP_DELAY_DONE]      = power_up_delay_done;
      end
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0 : rd_mux;
      pslverr <= ~rd_hit;
    end
  end

endmodule

//--- rss_props.sv
`timescale 1ns/1ps
`include "rss_defines.svh"

module rss_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // monitors and pin
  input wire logic        lp_brownout_low,
  input wire logic        prog_mode,
  input wire logic        external_reset_pin_in,
  input wire logic        external_reset_pin_out,
  input wire logic        external_reset_pin_oe,
  input wire logic        external_reset_pin_pullup,
  // core side
  input wire logic        watchdog_timeout,
  input wire logic        reset_instr,
  input wire logic        stack_overflow,
  input wire logic        core_reset_n,
  input wire logic        pc_hold,
  input wire logic        osc_stable
);
  logic [31:0] cfg_ff;
  logic        sw_pu_ff;
  logic [3:0]  low_cnt_ff;
  wire         wr     = psel && penable && pwrite && pready;
  wire         pin_en = cfg_ff[5] | cfg_ff[6];
  wire         bad    = paddr > `RSS_ADDR_CTRL || paddr[1:0] != 2'h0;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadow copies of the configuration and software pull-up
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cfg_ff <= `RSS_CFG_RST;
    else if (wr && paddr == `RSS_ADDR_CFG) cfg_ff <= pwdata & `RSS_CFG_WMASK;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) sw_pu_ff <= 1'b0;
    else if (wr && paddr == `RSS_ADDR_CTRL) sw_pu_ff <= pwdata[0];
  // consecutive cycles of an enabled pin held low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_cnt_ff <= 4'h0;
    else if (external_reset_pin_in || !pin_en) low_cnt_ff <= 4'h0;
    else if (low_cnt_ff != 4'hf) low_cnt_ff <= low_cnt_ff + 4'h1;

  a_pin_input_only: assert property (
    !external_reset_pin_oe && !external_reset_pin_out)
    else $error("reset pin driven by the device");
  a_prog_reset: assert property (
    prog_mode[*5] |-> !core_reset_n) else $error("prog mode not reset");
  a_low_power_brownout_detector_reset: assert property (
    (lp_brownout_low && cfg_ff[4])[*5] |-> !core_reset_n)
    else $error("low-power detector did not hold reset");
  a_pin_reset: assert property (
    low_cnt_ff >= 4'hc |-> !core_reset_n) else $error("pin low not reset");
  a_run_no_hold: assert property (
    osc_stable && $past(osc_stable) |-> !pc_hold)
    else $error("pc held while running");
  a_pullup_pin: assert property (
    $stable(cfg_ff) && pin_en |-> external_reset_pin_pullup)
    else $error("pull-up off with pin enabled");
  a_pullup_sw: assert property (
    $stable(cfg_ff) && $stable(sw_pu_ff) && !pin_en
    |-> external_reset_pin_pullup == sw_pu_ff)
    else $error("pull-up not under software");
  a_stack_reset: assert property (
    stack_overflow && cfg_ff[7] |-> ##[1:5] !core_reset_n)
    else $error("stack fault did not reset");
  a_wdt_reset: assert property (
    watchdog_timeout |-> ##[1:5] !core_reset_n)
    else $error("watchdog did not reset");
  a_ri_reset: assert property (
    reset_instr |-> ##[1:5] !core_reset_n)
    else $error("reset instruction did not reset");
  a_slverr_map: assert property (
    psel && !penable |=> pslverr == $past(bad))
    else $error("error response wrong for address");

  c_osc_run: cover property ($rose(osc_stable));
  c_stack: cover property (stack_overflow && cfg_ff[7]);
  c_pin_low: cover property (low_cnt_ff == 4'hf);
endmodule

//--- rss_far_side.sv
`timescale 1ns/1ps

module rss_far_side (
  // clock
  input  wire logic pclk,
  // bench commands
  input  wire logic drv_low,
  input  wire logic sup_low,
  input  wire logic lp_low,
  input  wire logic xtal_on,
  // device pin controls
  input  wire logic pu,
  input  wire logic oe,
  input  wire logic dout,
  // lines into the device
  output logic      pin,
  output logic      bor,
  output logic      low_power_brownout_detector,
  output logic      xtal,
  output int        xtal_n
);
  logic flt = 1'b0;
  initial xtal = 1'b0;
  initial xtal_n = 0;
  // an undriven, unpulled pin floats: model it as a moving level
  always @(posedge pclk) flt <= !flt;
  assign pin = drv_low ? 1'b0 : oe ? dout : pu ? 1'b1 : flt;
  assign bor = sup_low;
  assign low_power_brownout_detector = lp_low;
  // crystal stands still unless powered; period unrelated to pclk
  always #55 if (xtal_on) xtal = !xtal;
  always @(posedge xtal) xtal_n++;
endmodule

//--- rss_tb.sv
`timescale 1ns/1ps
`include "rss_defines.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module testbench;
  localparam int POWER_UP_DELAY = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        brownout_low, lp_brownout_low, prog_mode, crystal_input_pin;
  logic        external_reset_pin_in, external_reset_pin_out;
  logic        external_reset_pin_oe, external_reset_pin_pullup;
  logic        external_reset_pin_gpio, watchdog_timeout, reset_instr;
  logic        stack_overflow, stack_underflow, sleep_enter, wake_event;
  logic        core_reset_n, pc_hold, clk_sel_internal, osc_stable;
  logic        drv_low, sup_low, lp_low, xtal_on;
  int          n_mismatch, n_checks, xtal_n, c, n0;

  rss_reset_sequencer #(.POWER_UP_DELAY_CYCLES(POWER_UP_DELAY)) i_rss_reset_sequencer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .brownout_low, .lp_brownout_low, .prog_mode,
    .crystal_input_pin, .external_reset_pin_in, .external_reset_pin_out,
    .external_reset_pin_oe, .external_reset_pin_pullup,
    .external_reset_pin_gpio, .watchdog_timeout, .reset_instr,
    .stack_overflow, .stack_underflow, .sleep_enter, .wake_event,
    .core_reset_n, .pc_hold, .clk_sel_internal, .osc_stable);
  rss_far_side i_rss_far_side (
    .pclk, .drv_low, .sup_low, .lp_low, .xtal_on,
    .pu(external_reset_pin_pullup), .oe(external_reset_pin_oe),
    .dout(external_reset_pin_out), .pin(external_reset_pin_in),
    .bor(brownout_low), .low_power_brownout_detector(lp_brownout_low),
    .xtal(crystal_input_pin), .xtal_n);

  always #12.5 pclk = ~pclk;

  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_mismatch++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // counts edges until s shows v; running out of the bound ends the run
  task automatic wt(ref logic s, input logic v, input int n);
    c = 0;
    while (s !== v) begin
      @(posedge pclk);
      c++;
      if (c > n) begin
        n_mismatch++;
        wrap_up();
      end
    end
  endtask

  task automatic fire(input int i, input int n);
    case (i)
      0: watchdog_timeout <= 1'b1;
      1: reset_instr <= 1'b1;
      2: stack_overflow <= 1'b1;
      3: stack_underflow <= 1'b1;
      4: sup_low <= 1'b1;
      5: lp_low <= 1'b1;
      6: prog_mode <= 1'b1;
      7: drv_low <= 1'b1;
      8: sleep_enter <= 1'b1;
      default: wake_event <= 1'b1;
    endcase
    repeat (n) @(posedge pclk);
    {watchdog_timeout, reset_instr, stack_overflow, stack_underflow} <= 4'h0;
    {sup_low, lp_low, prog_mode, drv_low, sleep_enter, wake_event} <= 6'h0;
    @(posedge pclk);
  endtask

  task automatic t_boot;
    wt(core_reset_n, 1'b1, 50);
    `CHK("pc_hold", 1'b0, pc_hold)
    `CHK("pin_oe", 1'b0, external_reset_pin_oe)
    `CHK("pullup", 1'b1, external_reset_pin_pullup)
  endtask

  task automatic t_regs;
    apb(1'b0, `RSS_ADDR_CFG, 32'h0);
    `CHK("cfg_rst", 32'h620, q)
    apb(1'b0, `RSS_ADDR_CAUSE, 32'h0);
    `CHK("cause_rst", 32'h3e, q)
    apb(1'b1, `RSS_ADDR_CFG, 32'hffff_fe20);
    apb(1'b0, `RSS_ADDR_CFG, 32'h0);
    `CHK("cfg_mask", 32'h620, q)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, q)
    apb(1'b0, `RSS_ADDR_STAT, 32'h0);
    `CHK("state_run", 3'h3, q[2:0])
  endtask

  task automatic t_pin;
    apb(1'b1, `RSS_ADDR_CAUSE, 32'h3f);
    fire(7, 2);
    repeat (15) @(posedge pclk);
    `CHK("glitch", 1'b1, core_reset_n)
    fire(7, 20);
    `CHK("pin_hold", 1'b0, core_reset_n)
    wt(core_reset_n, 1'b1, 100);
    apb(1'b0, `RSS_ADDR_CAUSE, 32'h0);
    `CHK("pin_cause", 32'h37, q)
  endtask

  task automatic t_gpio;
    apb(1'b1, `RSS_ADDR_CFG, 32'h600);
    apb(1'b1, `RSS_ADDR_CTRL, 32'h0);
    `CHK("sw_pu_off", 1'b0, external_reset_pin_pullup)
    apb(1'b1, `RSS_ADDR_CTRL, 32'h1);
    @(posedge pclk);
    `CHK("sw_pu_on", 1'b1, external_reset_pin_pullup)
    drv_low <= 1'b1;
    repeat (20) @(posedge pclk);
    `CHK("gpio_lvl", 1'b0, external_reset_pin_gpio)
    `CHK("pin_off", 1'b1, core_reset_n)
    drv_low <= 1'b0;
    // let the filter see the pin high before the pin function returns
    repeat (8) @(posedge pclk);
    apb(1'b1, `RSS_ADDR_CFG, 32'h640);
    fire(7, 20);
    `CHK("lvp_pin_on", 1'b0, core_reset_n)
    wt(core_reset_n, 1'b1, 100);
    apb(1'b1, `RSS_ADDR_CFG, 32'h620);
  endtask

  task automatic t_causes;
    logic [7:0] ex [6] = '{8'h2f, 8'h3b, 8'hbf, 8'h7f, 8'h3d, 8'h3d};
    // low-power detector paired with the normal one off in sleep
    apb(1'b1, `RSS_ADDR_CFG, 32'h4b0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `RSS_ADDR_CAUSE, 32'h3f);
      fire(i, i < 4 ? 1 : 8);
      wt(core_reset_n, 1'b1, 200);
      apb(1'b0, `RSS_ADDR_CAUSE, 32'h0);
      `CHK("cause", {24'h0, ex[i]}, q)
    end
    apb(1'b1, `RSS_ADDR_CFG, 32'h420);
    fire(2, 1);
    repeat (8) @(posedge pclk);
    `CHK("stack_off", 1'b1, core_reset_n)
    apb(1'b1, `RSS_ADDR_CFG, 32'h620);
  endtask

  task automatic t_power_up_delay;
    apb(1'b1, `RSS_ADDR_CFG, 32'h720);
    apb(1'b1, `RSS_ADDR_CAUSE, 32'h3f);
    fire(6, 6);
    wt(core_reset_n, 1'b1, 200);
    `CHK("power_up_delay_len", 1'b1, c >= POWER_UP_DELAY - 2 && c <= POWER_UP_DELAY + 12)
    apb(1'b0, `RSS_ADDR_CAUSE, 32'h0);
    `CHK("por_flag", 1'b0, q[0])
    prog_mode <= 1'b1;
    drv_low <= 1'b1;
    repeat (6) @(posedge pclk);
    prog_mode <= 1'b0;
    repeat (60) @(posedge pclk);
    `CHK("pin_wait", 1'b0, core_reset_n)
    drv_low <= 1'b0;
    @(posedge pclk);
    wt(core_reset_n, 1'b1, 100);
    `CHK("pin_rel", 1'b1, c >= 17 && c <= 24)
    apb(1'b1, `RSS_ADDR_CFG, 32'h620);
  endtask

  task automatic t_xtal;
    xtal_on <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `RSS_ADDR_CFG, m == 0 ? 32'h621 : 32'h629);
      fire(8, 1);
      repeat (4) @(posedge pclk);
      // an edge in the cycle just before wake is still counted
      n0 = xtal_n;
      @(posedge pclk);
      fire(9, 1);
      repeat (3) @(posedge pclk);
      `CHK("ost_hold", m == 0, pc_hold)
      `CHK("ost_clk", 1'b1, clk_sel_internal)
      `CHK("ost_wait", 1'b0, osc_stable)
      wt(osc_stable, 1'b1, 6000);
      `CHK("ost_len", 1'b1, xtal_n - n0 inside {[1024:1030]})
      `CHK("xtal_clk", 1'b0, clk_sel_internal)
    end
    xtal_on <= 1'b0;
    apb(1'b1, `RSS_ADDR_CFG, 32'h620);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    {watchdog_timeout, reset_instr, stack_overflow, stack_underflow} = 4'h0;
    {sup_low, lp_low, prog_mode, drv_low, sleep_enter, wake_event} = 6'h0;
    xtal_on = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_boot();
    t_regs();
    t_pin();
    t_gpio();
    t_causes();
    t_power_up_delay();
    t_xtal();
    wrap_up();
  end
endmodule

bind rss_reset_sequencer rss_props i_rss_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .lp_brownout_low, .prog_mode, .external_reset_pin_in,
  .external_reset_pin_out, .external_reset_pin_oe,
  .external_reset_pin_pullup, .watchdog_timeout, .reset_instr,
  .stack_overflow, .core_reset_n, .pc_hold, .osc_stable);
